// >>> rtl/slb_lamp_ctrl.sv
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
// Operation
// - LED sense voltage arrives as a 10-bit converter result used as current feedback.
// - Every conversion-done pulse is acted upon by the control logic.
// - Each conversion captures the current sample and the battery sample.
// - Current samples are accumulated and averaged before any duty change.
// - Average below set point raises the duty by one step.
// - Average above set point lowers the duty by one step.
// - Battery samples are averaged into a stored battery level.
// - Button presses cycle off, full, dim one, dim two, off.
// - Two dimmed levels, each with its own programmable setting.
// - Full level uses a programmable setting; larger means brighter.
// - While lit, an open string forces drive off at once.
// - Charging lamp blinks while charging, steady once battery full.
// - Weak battery lamp lights when battery level is below threshold.
// - Programmable low-battery cutoff turns the lamp off.
// - Phone charger output follows battery level with selectable polarity.
// - In manual mode each discrete output can be set and cleared on its own, except where overcharge or low battery forces it.
// - Charge switch opens when battery exceeds the overcharge threshold.
module slb_lamp_ctrl
    import slb_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = slb_pkg::DEBOUNCE_CYC,
    parameter int BLINK_CYCLES    = slb_pkg::BLINK_CYC,
    parameter int AVG_SHIFT       = slb_pkg::AVG_LOG2
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Converter results, same clock
    input  wire logic        adcDone,
    input  wire logic [9:0]  adcCurrent,
    input  wire logic [9:0]  adcBattery,
    // Pins
    input  wire logic        buttonPin,
    input  wire logic        openStringPin,
    input  wire logic        chargeSourcePin,
    // Drive and indicator outputs
    output logic             pwmOut,
    output logic             chargeSwitch,
    output logic             phoneCharger,
    output logic             chargingLamp,
    output logic             weakBattLamp,
    output logic             irq
);
    import slb_pkg::*;

    localparam int DB_W  = $clog2(DEBOUNCE_CYCLES + 1);
    localparam int BL_W  = $clog2(BLINK_CYCLES + 1);
    localparam int SUM_W = ADC_W + AVG_SHIFT;
    localparam logic [ADC_W-1:0]     DUTY_MAX = '1;
    localparam logic [DB_W-1:0]      DB_LAST  = DB_W'(DEBOUNCE_CYCLES - 1);
    localparam logic [BL_W-1:0]      BL_LAST  = BL_W'(BLINK_CYCLES - 1);
    localparam logic [AVG_SHIFT-1:0] SMP_LAST = '1;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                 btnS1, btnS2, openS1, openS2, srcS1, srcS2;
        logic                 btnStable;
        logic [DB_W-1:0]      dbCnt;
        slb_lamp_e            lamp;
        logic                 fault;
        logic [ADC_W-1:0]     currHold, battHold;
        logic [SUM_W-1:0]     currSum, battSum;
        logic [AVG_SHIFT-1:0] smpCnt;
        logic [ADC_W-1:0]     currAvg, battLevel;
        logic                 battValid;
        logic [ADC_W-1:0]     duty, pwmCnt;
        logic [BL_W-1:0]      blinkCnt;
        logic                 blinkPh;
        logic [1:0]           ctrl;
        logic [3:0]           outReg;
        logic [ADC_W-1:0]     fullDuty, dim1, dim2, lowThr, overThr;
        logic [EV_N-1:0]      irqStat, irqMask;
        logic [31:0]          prdata;
        logic                 pready, pslverr;
        logic                 pwmOut, chargeSwitch, phoneCharger, chargingLamp, weakBattLamp, irq;
    } slb_state_s;

    slb_state_s st_q;
    slb_state_s st_d;
    logic       rstS1_q;
    logic       rstSync_b;

    // Combinational helpers, visible to the checks below
    logic             press;
    logic             avgFire;
    logic [ADC_W-1:0] newAvg;
    logic [ADC_W-1:0] setPoint;
    logic             lowBatt;
    logic             overCharge;
    logic [EV_N-1:0]  events;
    logic [SUM_W-1:0] currTot;
    logic [SUM_W-1:0] battTot;
    logic             wrAcc;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstS1_q   <= 1'b0;
            rstSync_b <= 1'b0;
        end else begin
            rstS1_q   <= 1'b1;
            rstSync_b <= rstS1_q;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d     = st_q;
        press    = 1'b0;
        avgFire  = 1'b0;
        events   = '0;
        currTot  = st_q.currSum + SUM_W'(adcCurrent);
        battTot  = st_q.battSum + SUM_W'(adcBattery);
        newAvg   = currTot[SUM_W-1:AVG_SHIFT];
        wrAcc    = psel && penable && pwrite && st_q.pready;

        // Pins pass two flops before use
        st_d.btnS1  = buttonPin;
        st_d.btnS2  = st_q.btnS1;
        st_d.openS1 = openStringPin;
        st_d.openS2 = st_q.openS1;
        st_d.srcS1  = chargeSourcePin;
        st_d.srcS2  = st_q.srcS1;

        // Level must hold a full debounce time before it is believed
        if (st_q.btnS2 != st_q.btnStable) begin
            if (st_q.dbCnt == DB_LAST) begin
                st_d.dbCnt     = '0;
                st_d.btnStable = st_q.btnS2;
                press          = st_q.btnS2;
            end else begin
                st_d.dbCnt = st_q.dbCnt + DB_W'(1);
            end
        end else begin
            st_d.dbCnt = '0;
        end

        // Sample capture and averaging
        if (adcDone) begin
            st_d.currHold = adcCurrent;
            st_d.battHold = adcBattery;
            if (st_q.smpCnt == SMP_LAST) begin
                avgFire        = 1'b1;
                st_d.currAvg   = newAvg;
                st_d.battLevel = battTot[SUM_W-1:AVG_SHIFT];
                st_d.battValid = 1'b1;
                st_d.currSum   = '0;
                st_d.battSum   = '0;
            end else begin
                st_d.currSum = currTot;
                st_d.battSum = battTot;
            end
            st_d.smpCnt = st_q.smpCnt + AVG_SHIFT'(1);
        end

        lowBatt    = st_q.battValid && (st_q.battLevel < st_q.lowThr);
        overCharge = st_q.battValid && (st_q.battLevel > st_q.overThr);

        // Lamp sequence
        if (press) begin
            st_d.fault = 1'b0;
            case (st_q.lamp)
                SLB_OFF:  st_d.lamp = SLB_FULL;
                SLB_FULL: st_d.lamp = SLB_DIM1;
                SLB_DIM1: st_d.lamp = SLB_DIM2;
                SLB_DIM2: st_d.lamp = SLB_OFF;
                default:  st_d.lamp = SLB_OFF;
            endcase
        end
        if (lowBatt && st_d.lamp != SLB_OFF) begin
            st_d.lamp           = SLB_OFF;
            events[EV_CUTOFF]   = 1'b1;
        end
        if (st_q.openS2 && st_q.lamp != SLB_OFF) begin
            st_d.lamp         = SLB_OFF;
            st_d.fault        = 1'b1;
            events[EV_OPEN]   = 1'b1;
        end

        case (st_q.lamp)
            SLB_FULL: setPoint = st_q.fullDuty;
            SLB_DIM1: setPoint = st_q.dim1;
            SLB_DIM2: setPoint = st_q.dim2;
            default:  setPoint = '0;
        endcase

        // Closed loop: one step per completed average
        if (st_d.lamp == SLB_OFF || st_d.fault) begin
            st_d.duty = '0;
        end else if (avgFire) begin
            if (newAvg < setPoint && st_q.duty != DUTY_MAX) begin
                st_d.duty = st_q.duty + ADC_W'(1);
            end else if (newAvg > setPoint && st_q.duty != '0) begin
                st_d.duty = st_q.duty - ADC_W'(1);
            end
        end
        st_d.pwmCnt = st_q.pwmCnt + ADC_W'(1);
        st_d.pwmOut = !st_d.fault && (st_q.pwmCnt < st_d.duty);

        // Blink rate enable
        if (st_q.blinkCnt == BL_LAST) begin
            st_d.blinkCnt = '0;
            st_d.blinkPh  = ~st_q.blinkPh;
        end else begin
            st_d.blinkCnt = st_q.blinkCnt + BL_W'(1);
        end

        // APB: one wait state, data and error registered
        st_d.pready  = psel && penable && !st_q.pready;
        st_d.pslverr = 1'b0;
        if (psel && penable && !st_q.pready) begin
            st_d.prdata = '0;
            case (paddr)
                OFF_CTRL:     st_d.prdata[1:0] = st_q.ctrl;
                OFF_OUTSET,
                OFF_OUTCLR:   st_d.prdata = '0;
                OFF_OUTSTAT:  st_d.prdata[4:0] = {st_q.pwmOut, st_q.weakBattLamp, st_q.chargingLamp,
                                                  st_q.phoneCharger, st_q.chargeSwitch};
                OFF_FULLDUTY: st_d.prdata[9:0] = st_q.fullDuty;
                OFF_DIM1:     st_d.prdata[9:0] = st_q.dim1;
                OFF_DIM2:     st_d.prdata[9:0] = st_q.dim2;
                OFF_LOWTHR:   st_d.prdata[9:0] = st_q.lowThr;
                OFF_OVERTHR:  st_d.prdata[9:0] = st_q.overThr;
                OFF_STATUS:   st_d.prdata[14:0] = {st_q.battValid, st_q.fault, st_q.lamp,
                                                   1'b0, st_q.duty};
                OFF_MEAS:     st_d.prdata[25:0] = {st_q.battLevel, 6'h00, st_q.currAvg};
                OFF_IRQSTAT:  st_d.prdata[4:0] = st_q.irqStat;
                OFF_IRQMASK:  st_d.prdata[4:0] = st_q.irqMask;
                default:      st_d.pslverr = 1'b1;
            endcase
        end
        if (wrAcc) begin
            case (paddr)
                OFF_CTRL:     st_d.ctrl     = pwdata[1:0];
                OFF_OUTSET:   st_d.outReg   = st_q.outReg | pwdata[3:0];
                OFF_OUTCLR:   st_d.outReg   = st_q.outReg & ~pwdata[3:0];
                OFF_FULLDUTY: st_d.fullDuty = pwdata[9:0];
                OFF_DIM1:     st_d.dim1     = pwdata[9:0];
                OFF_DIM2:     st_d.dim2     = pwdata[9:0];
                OFF_LOWTHR:   st_d.lowThr   = pwdata[9:0];
                OFF_OVERTHR:  st_d.overThr  = pwdata[9:0];
                OFF_IRQMASK:  st_d.irqMask  = pwdata[4:0];
                default:      st_d.ctrl     = st_q.ctrl;
            endcase
        end

        // Discrete outputs; automatic control overrides software in auto mode
        st_d.chargeSwitch = st_q.outReg[OUT_CHG_SW] && !overCharge;
        if (st_q.ctrl[CTRL_AUTO]) begin
            st_d.phoneCharger = !lowBatt ^ st_q.ctrl[CTRL_PHONE_POL];
            if (overCharge) begin
                st_d.chargingLamp = 1'b1;
            end else if (st_q.srcS2 && st_q.outReg[OUT_CHG_SW]) begin
                st_d.chargingLamp = st_q.blinkPh;
            end else begin
                st_d.chargingLamp = st_q.outReg[OUT_CHG_LAMP];
            end
        end else begin
            st_d.phoneCharger = st_q.outReg[OUT_PHONE] ^ st_q.ctrl[CTRL_PHONE_POL];
            st_d.chargingLamp = st_q.outReg[OUT_CHG_LAMP];
        end
        st_d.weakBattLamp = st_q.outReg[OUT_WEAK_LAMP] || lowBatt;

        // Interrupts: a new event wins over a same-cycle clear
        events[EV_AVG]   = avgFire;
        events[EV_OVER]  = overCharge;
        events[EV_PRESS] = press;
        st_d.irqStat = st_q.irqStat | events;
        if (wrAcc && paddr == OFF_IRQSTAT) begin
            st_d.irqStat = (st_q.irqStat & ~pwdata[4:0]) | events;
        end
        st_d.irq = |(st_d.irqStat & st_d.irqMask);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            st_q          <= '0;
            st_q.lamp     <= SLB_OFF;
            st_q.ctrl     <= RST_CTRL;
            st_q.outReg   <= RST_OUT;
            st_q.fullDuty <= RST_FULLDUTY;
            st_q.dim1     <= RST_DIM1;
            st_q.dim2     <= RST_DIM2;
            st_q.lowThr   <= RST_LOWTHR;
            st_q.overThr  <= RST_OVERTHR;
            st_q.irqMask  <= RST_IRQMASK;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata       = st_q.prdata;
    assign pready       = st_q.pready;
    assign pslverr      = st_q.pslverr;
    assign pwmOut       = st_q.pwmOut;
    assign chargeSwitch = st_q.chargeSwitch;
    assign phoneCharger = st_q.phoneCharger;
    assign chargingLamp = st_q.chargingLamp;
    assign weakBattLamp = st_q.weakBattLamp;
    assign irq          = st_q.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_capture;
        @(posedge clk) disable iff (!rstSync_b)
        adcDone |=> (st_q.currHold == $past(adcCurrent)) && (st_q.battHold == $past(adcBattery));
    endproperty
    a_capture: assert property (p_capture) else $error("sample not captured");

    property p_raise;
        @(posedge clk) disable iff (!rstSync_b)
        avgFire && newAvg < setPoint && st_d.lamp != SLB_OFF && !st_d.fault && st_q.duty != DUTY_MAX
        |=> st_q.duty == $past(st_q.duty) + ADC_W'(1);
    endproperty
    a_raise: assert property (p_raise) else $error("duty did not rise");

    property p_lower;
        @(posedge clk) disable iff (!rstSync_b)
        avgFire && newAvg > setPoint && st_d.lamp != SLB_OFF && !st_d.fault && st_q.duty != '0
        |=> st_q.duty == $past(st_q.duty) - ADC_W'(1);
    endproperty
    a_lower: assert property (p_lower) else $error("duty did not fall");

    property p_hold;
        @(posedge clk) disable iff (!rstSync_b)
        !avgFire && st_d.lamp != SLB_OFF && !st_d.fault |=> $stable(st_q.duty);
    endproperty
    a_hold: assert property (p_hold) else $error("duty moved without an average");

    property p_open;
        @(posedge clk) disable iff (!rstSync_b)
        st_q.openS2 && st_q.lamp != SLB_OFF |=> st_q.fault && st_q.lamp == SLB_OFF ##1 !pwmOut;
    endproperty
    a_open: assert property (p_open) else $error("open string left drive on");

    property p_seq;
        @(posedge clk) disable iff (!rstSync_b)
        press && st_q.lamp == SLB_OFF && !lowBatt && !st_q.openS2 |=> st_q.lamp == SLB_FULL;
    endproperty
    a_seq: assert property (p_seq) else $error("first press did not light");

    property p_over;
        @(posedge clk) disable iff (!rstSync_b)
        overCharge |=> !chargeSwitch;
    endproperty
    a_over: assert property (p_over) else $error("charge switch on above overcharge");

    property p_weak;
        @(posedge clk) disable iff (!rstSync_b)
        lowBatt |=> weakBattLamp && st_q.lamp == SLB_OFF;
    endproperty
    a_weak: assert property (p_weak) else $error("low battery not handled");

    property p_irq;
        @(posedge clk) disable iff (!rstSync_b)
        irq == |(st_q.irqStat & st_q.irqMask);
    endproperty
    a_irq: assert property (p_irq) else $error("irq disagrees with status");

    c_fault: cover property (@(posedge clk) disable iff (!rstSync_b) $rose(st_q.fault));
    c_dim2:  cover property (@(posedge clk) disable iff (!rstSync_b) st_q.lamp == SLB_DIM2);
    c_raise: cover property (@(posedge clk) disable iff (!rstSync_b) avgFire && newAvg < setPoint);
endmodule

// >>> rtl/slb_pkg.sv
package slb_pkg;
    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_OUTSET   = 8'h04;
    localparam logic [7:0] OFF_OUTCLR   = 8'h08;
    localparam logic [7:0] OFF_OUTSTAT  = 8'h0C;
    localparam logic [7:0] OFF_FULLDUTY = 8'h10;
    localparam logic [7:0] OFF_DIM1     = 8'h14;
    localparam logic [7:0] OFF_DIM2     = 8'h18;
    localparam logic [7:0] OFF_LOWTHR   = 8'h1C;
    localparam logic [7:0] OFF_OVERTHR  = 8'h20;
    localparam logic [7:0] OFF_STATUS   = 8'h24;
    localparam logic [7:0] OFF_MEAS     = 8'h28;
    localparam logic [7:0] OFF_IRQSTAT  = 8'h2C;
    localparam logic [7:0] OFF_IRQMASK  = 8'h30;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_AUTO      = 0;
    localparam int CTRL_PHONE_POL = 1;
    localparam int OUT_CHG_SW     = 0;
    localparam int OUT_PHONE      = 1;
    localparam int OUT_CHG_LAMP   = 2;
    localparam int OUT_WEAK_LAMP  = 3;
    localparam int EV_AVG         = 0;
    localparam int EV_OPEN        = 1;
    localparam int EV_CUTOFF      = 2;
    localparam int EV_OVER        = 3;
    localparam int EV_PRESS       = 4;
    localparam int EV_N           = 5;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [1:0]  RST_CTRL     = 2'h1;
    localparam logic [3:0]  RST_OUT      = 4'h1;
    localparam logic [9:0]  RST_FULLDUTY = 10'h200;
    localparam logic [9:0]  RST_DIM1     = 10'h155;
    localparam logic [9:0]  RST_DIM2     = 10'h0AA;
    localparam logic [9:0]  RST_LOWTHR   = 10'h180;
    localparam logic [9:0]  RST_OVERTHR  = 10'h3A0;
    localparam logic [4:0]  RST_IRQMASK  = 5'h00;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ        = 20000000;
    localparam int DEBOUNCE_US   = 20000;
    localparam int DEBOUNCE_CYC  = (DEBOUNCE_US * (CLK_HZ / 1000000));
    localparam int BLINK_MS      = 250;
    localparam int BLINK_CYC     = (BLINK_MS * (CLK_HZ / 1000));
    localparam int ADC_W         = 10;
    localparam int AVG_LOG2      = 4;
    // ----------------------------------------------------------------
    // Lamp states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SLB_OFF  = 2'b00,
        SLB_FULL = 2'b01,
        SLB_DIM1 = 2'b10,
        SLB_DIM2 = 2'b11
    } slb_lamp_e;
endpackage

// >>> tb/slb_far_side.sv
`timescale 1ns/1ps
module slb_far_side (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Bench requests
    input  wire logic       go,
    input  wire logic       push,
    input  wire logic [9:0] curr,
    input  wire logic [9:0] batt,
    // Converter and button
    output logic            adcDone,
    output logic      [9:0] adcCurrent,
    output logic      [9:0] adcBattery,
    output logic            buttonPin,
    output logic            busy
);
    int nConv;
    int tBtn;
    // -------------------------------------------
    // One burst is 16 conversions, 3 clocks apart
    // -------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nConv <= 0;
            tBtn <= 0;
            adcDone <= 1'b0;
            adcCurrent <= 10'h000;
            adcBattery <= 10'h000;
        end else begin
            nConv <= go ? 48 : (nConv > 0 ? nConv - 1 : 0);
            tBtn <= push ? 46 : (tBtn > 0 ? tBtn - 1 : 0);
            adcDone <= (nConv % 3 == 1);
            // Results only mean something beside the done pulse
            adcCurrent <= (nConv % 3 == 1) ? curr : ~adcCurrent;
            adcBattery <= (nConv % 3 == 1) ? batt : ~adcBattery;
        end
    end
    // Short bounce first, then a real press and release
    assign buttonPin = (tBtn >= 45) || (tBtn <= 42 && tBtn >= 23);
    assign busy = (nConv != 0) || (tBtn != 0);
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import slb_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        openStringPin = 1'b0;
    logic        chargeSourcePin = 1'b0;
    logic        go = 1'b0;
    logic        push = 1'b0;
    logic [9:0]  curr = 10'h160;
    logic [9:0]  batt = 10'h250;
    logic [31:0] prdata, q;
    logic [9:0]  adcCurrent, adcBattery, d;
    logic        pready, pslverr, adcDone, buttonPin, busy, pwmOut, err, b;
    logic        chargeSwitch, phoneCharger, chargingLamp, weakBattLamp, irq;
    int          failures = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          k;
    logic [7:0]  ra [8] = '{OFF_CTRL, OFF_OUTSTAT, OFF_FULLDUTY, OFF_DIM1, OFF_DIM2, OFF_LOWTHR, OFF_OVERTHR,
                            OFF_IRQMASK};
    logic [31:0] rv [8] = '{32'(RST_CTRL), 32'h3, 32'(RST_FULLDUTY), 32'(RST_DIM1), 32'(RST_DIM2),
                            32'(RST_LOWTHR), 32'(RST_OVERTHR), 32'(RST_IRQMASK)};

    slb_lamp_ctrl #(.DEBOUNCE_CYCLES(8), .BLINK_CYCLES(16), .AVG_SHIFT(4)) uut (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .adcDone(adcDone),
        .adcCurrent(adcCurrent), .adcBattery(adcBattery), .buttonPin(buttonPin),
        .openStringPin(openStringPin), .chargeSourcePin(chargeSourcePin), .pwmOut(pwmOut),
        .chargeSwitch(chargeSwitch), .phoneCharger(phoneCharger), .chargingLamp(chargingLamp),
        .weakBattLamp(weakBattLamp), .irq(irq));
    slb_far_side far_end (.clk(clk), .rst_b(rst_b), .go(go), .push(push), .curr(curr), .batt(batt),
        .adcDone(adcDone), .adcCurrent(adcCurrent), .adcBattery(adcBattery), .buttonPin(buttonPin),
        .busy(busy));

    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end
    // -------------------------------------------
    // Bus, stimulus and compare tasks
    // -------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
        repeat (3) @(posedge clk);
    endtask
    task automatic far(input logic g, input logic p);
        go <= g;
        push <= p;
        @(posedge clk);
        go <= 1'b0;
        push <= 1'b0;
        @(posedge clk);
        while (busy) @(posedge clk);
        repeat (6) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // -------------------------------------------
    // Test sequence
    // -------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rd(ra[i]);
            chk(q, rv[i]);
        end
        rd(8'h40);
        chk(q, 32'h0);
        chk(err, 1'b1);
        $display("register test done");
        far(1'b1, 1'b0);
        rd(OFF_MEAS);
        chk(q, {6'h0, 10'h250, 6'h0, 10'h160});
        // Sense sits above both dim targets but below the full one
        far(1'b0, 1'b1);
        for (int i = 0; i < 3; i++) begin
            rd(OFF_STATUS);
            chk(q[12:11], i + 1);
            d = q[9:0];
            far(1'b1, 1'b0);
            rd(OFF_STATUS);
            chk(q[9:0], (i == 0) ? d + 10'h1 : ((d == 10'h0) ? d : d - 10'h1));
            if (i == 0) begin
                // Duty of one step gives one high cycle in each 1024-cycle period
                k = 0;
                repeat (1024) begin
                    @(posedge clk);
                    if (pwmOut === 1'b1)
                        k++;
                end
                chk(k, 1);
            end
            far(1'b0, 1'b1);
        end
        rd(OFF_STATUS);
        chk(q[12:11], SLB_OFF);
        $display("regulation test done");
        far(1'b0, 1'b1);
        openStringPin <= 1'b1;
        repeat (5) @(posedge clk);
        openStringPin <= 1'b0;
        rd(OFF_STATUS);
        chk(q[13:11], 3'b100);
        rd(OFF_IRQSTAT);
        chk(q[EV_OPEN], 1'b1);
        chk(irq, 1'b0);
        wr(OFF_IRQMASK, 32'h2);
        chk(irq, 1'b1);
        wr(OFF_IRQSTAT, 32'h2);
        chk(irq, 1'b0);
        $display("open string test done");
        far(1'b0, 1'b1);
        batt <= 10'h100;
        far(1'b1, 1'b0);
        rd(OFF_STATUS);
        chk(q[12:11], SLB_OFF);
        chk({weakBattLamp, phoneCharger}, 2'b10);
        far(1'b0, 1'b1);
        rd(OFF_STATUS);
        chk(q[12:11], SLB_OFF);
        batt <= 10'h3B0;
        far(1'b1, 1'b0);
        chk({chargeSwitch, chargingLamp}, 2'b01);
        batt <= 10'h250;
        chargeSourcePin <= 1'b1;
        far(1'b1, 1'b0);
        chk(chargeSwitch, 1'b1);
        k = 0;
        repeat (64) begin
            b = chargingLamp;
            @(posedge clk);
            if (chargingLamp !== b)
                k++;
        end
        chk(k >= 2, 1'b1);
        rd(OFF_IRQSTAT);
        chk({q[EV_OVER], q[EV_CUTOFF]}, 2'b11);
        $display("battery test done");
        chargeSourcePin <= 1'b0;
        wr(OFF_CTRL, 32'h0);
        wr(OFF_OUTCLR, 32'hF);
        chk({weakBattLamp, chargingLamp, phoneCharger, chargeSwitch}, 4'h0);
        wr(OFF_OUTSET, 32'hA);
        chk({weakBattLamp, chargingLamp, phoneCharger, chargeSwitch}, 4'hA);
        wr(OFF_CTRL, 32'h2);
        chk(phoneCharger, 1'b0);
        rd(OFF_OUTSTAT);
        chk(q[4:0], 5'h08);
        $display("output test done");
        results();
    end
endmodule
